/* File: fmsc_frontend_regs.sv */
// Register bank for excitation, bias, system monitor select and fault status
// Overview of operation
// - Magnitude field sets both excitation currents
// - Two routing fields steer each source
// - Both sources may share one pin
// - Level bit selects half or twelfth bias
// - Connect bits attach bias to pins
// - Three-bit selector picks monitor function
// - Code 010 routes temperature sensor
// - Codes 011/100 route supply monitors
// - Supply monitor disconnects inputs, gain one
// - Supply monitor works amplifier on or off
// - Codes 101-111 enable burn-out sources
// - Burn-out sources positive, sinks negative
// - One-byte fault status at 01h
// - Append bit prepends status to data
// - Fault flags update once per conversion
// - Power-on reset sets bit 7
// - Writing zero clears power-on flag
// - Bit 6 is active-low ready
// - Rail flags latch, update at conversion end
// - Bits 1:0 flag low reference
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module fmsc_frontend_regs
  import fmsc_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
) (
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         clkEn,
  // Wishbone classic slave
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [9:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  // Conversion side
  input  wire logic         convDone,
  input  wire fmsc_faults_s faultsLive,
  input  wire logic         dataByteReq,
  output logic      [7:0]   firstByte,
  output logic              firstIsStatus,
  // Analog controls
  output fmsc_analog_s      analogCtl
);

  // A zero hold-off would leave the counter with no width to count in
  if (STARTUP < 1) begin : gStartupBad
    $error("STARTUP must be at least one cycle");
  end

  logic [7:0] gainQ, exMagQ, exRouteQ, biasQ, sysQ;
  logic [7:0] statusQ;
  fmsc_faults_s faultAccQ;
  logic [$clog2(STARTUP+1)-1:0] startCntQ;
  logic readyQ;

  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a[9:2] == idx;
  endfunction

  logic req, wr, lane0;
  assign req   = cyc_i && stb_i && !ack_o;
  assign wr    = req && we_i;
  assign lane0 = sel_i[0];

  // Ready follows a short hold-off after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      startCntQ <= '0;
      readyQ    <= 1'b0;
    end else if (clkEn && !readyQ) begin
      if (startCntQ == ($clog2(STARTUP+1))'(STARTUP - 1)) readyQ <= 1'b1;
      startCntQ <= startCntQ + 1'b1;
    end
  end

  // Configuration registers, low byte lane only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gainQ    <= RST_CFG;
      exMagQ   <= RST_CFG;
      exRouteQ <= RST_CFG;
      biasQ    <= RST_CFG;
      sysQ     <= RST_CFG;
    end else if (clkEn && wr && lane0) begin
      if (hit(adr_i, IDX_GAIN)) begin
        gainQ <= dat_i[7:0];
      end else if (hit(adr_i, IDX_EXMAG)) begin
        exMagQ <= dat_i[7:0];
      end else if (hit(adr_i, IDX_EXROUTE)) begin
        exRouteQ <= dat_i[7:0];
      end else if (hit(adr_i, IDX_BIAS)) begin
        biasQ <= dat_i[7:0];
      end else if (hit(adr_i, IDX_SYSCTL)) begin
        sysQ <= dat_i[7:0];
      end
    end
  end

  // Faults accumulate during a conversion and restart at its end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      faultAccQ <= '0;
    end else if (clkEn) begin
      if (convDone) faultAccQ <= '0;
      else faultAccQ <= faultAccQ | faultsLive;
    end
  end

  // Status byte; power-on flag is set only by reset and cleared by a host write of zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statusQ <= RST_STATUS;
    end else if (clkEn) begin
      if (wr && lane0 && hit(adr_i, IDX_STATUS) && !dat_i[STAT_POR_BIT])
        statusQ[STAT_POR_BIT] <= 1'b0;
      statusQ[STAT_RDYN_BIT] <= !readyQ;
      if (convDone)
        statusQ[5:0] <= faultAccQ | faultsLive;
    end
  end

  // Read mux and ack; one answer per request, registered and acked the cycle after it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (clkEn) begin
      ack_o <= req;
      if (req && !we_i) begin
        if (hit(adr_i, IDX_STATUS)) dat_o <= {24'h0, statusQ};
        else if (hit(adr_i, IDX_GAIN)) dat_o <= {24'h0, gainQ};
        else if (hit(adr_i, IDX_EXMAG)) dat_o <= {24'h0, exMagQ};
        else if (hit(adr_i, IDX_EXROUTE)) dat_o <= {24'h0, exRouteQ};
        else if (hit(adr_i, IDX_BIAS)) dat_o <= {24'h0, biasQ};
        else if (hit(adr_i, IDX_SYSCTL)) dat_o <= {24'h0, sysQ};
        else dat_o <= '0;
      end
    end
  end

  // First byte of a data read: status when appending
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      firstByte     <= '0;
      firstIsStatus <= 1'b0;
    end else if (clkEn && dataByteReq) begin
      firstIsStatus <= sysQ[SYS_APPEND_BIT];
      firstByte     <= sysQ[SYS_APPEND_BIT] ? statusQ : 8'h00;
    end
  end

  // Monitor decode drives the analog path
  logic [2:0] mon;
  logic       supplyMon;
  assign mon       = sysQ[SYS_MON_LSB +: 3];
  assign supplyMon = (mon == MON_AVDD) || (mon == MON_DVDD);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      analogCtl <= '0;
    end else if (clkEn) begin
      analogCtl.exciteMagnitude  <= exMagQ[3:0];
      analogCtl.exciteRouteA     <= exRouteQ[3:0];
      analogCtl.exciteRouteB     <= exRouteQ[7:4];
      analogCtl.biasLevelSel     <= biasQ[BIAS_LEVEL_BIT];
      analogCtl.biasPinConnect   <= {biasQ[7], biasQ[5:0]};
      analogCtl.tempSensorSel    <= (mon == MON_TEMP);
      analogCtl.analogMonSel     <= (mon == MON_AVDD);
      analogCtl.digitalMonSel    <= (mon == MON_DVDD);
      analogCtl.inputsDisconnect <= supplyMon || (mon == MON_TEMP);
      analogCtl.ampGainEff       <= supplyMon ? GAIN_ONE
                                    : gainQ[GAIN_LSB +: 3];
      analogCtl.ampEnableField   <= gainQ[AMPEN_LSB +: 2];
      analogCtl.burnoutEnable    <= mon[2] && (mon[1] || mon[0]);
      analogCtl.burnoutLevel     <= (mon == MON_BO_02) ? 2'h1 :
                                    (mon == MON_BO_1)  ? 2'h2 :
                                    (mon == MON_BO_10) ? 2'h3 : 2'h0;
      analogCtl.statusAppend     <= sysQ[SYS_APPEND_BIT];
    end
  end

  // Checks
  sequence supplyPick;
    clkEn && supplyMon;
  endsequence

  sequence gainForced;
    analogCtl.ampGainEff == GAIN_ONE && analogCtl.inputsDisconnect;
  endsequence

  chk_supply_gain_one: assert property (
    @(posedge clk) disable iff (reset)
    supplyPick |=> gainForced)
    else $error("supply monitor did not force gain one");
  chk_temp_route: assert property (
    @(posedge clk) disable iff (reset)
    clkEn && mon == MON_TEMP |=> analogCtl.tempSensorSel && !analogCtl.analogMonSel)
    else $error("temperature sensor not routed");
  chk_burnout_codes: assert property (
    @(posedge clk) disable iff (reset)
    clkEn && mon == MON_BO_10 |=> analogCtl.burnoutEnable && analogCtl.burnoutLevel == 2'h3)
    else $error("burn-out level wrong");
  chk_por_sticky: assert property (
    @(posedge clk) disable iff (reset)
    statusQ[STAT_POR_BIT] && !(clkEn && wr && hit(adr_i, IDX_STATUS))
      |=> statusQ[STAT_POR_BIT])
    else $error("power-on flag dropped without write");
  chk_por_never_sets: assert property (
    @(posedge clk) disable iff (reset)
    !statusQ[STAT_POR_BIT] |=> !statusQ[STAT_POR_BIT])
    else $error("power-on flag set outside reset");
  chk_flags_hold: assert property (
    @(posedge clk) disable iff (reset)
    !(clkEn && convDone) |=> $stable(statusQ[5:0]))
    else $error("fault flags moved between conversions");
  chk_ready_bit: assert property (
    @(posedge clk) disable iff (reset)
    clkEn && readyQ |=> !statusQ[STAT_RDYN_BIT])
    else $error("ready flag not shown");
  chk_append_first: assert property (
    @(posedge clk) disable iff (reset)
    clkEn && dataByteReq && sysQ[SYS_APPEND_BIT]
      |=> firstIsStatus && firstByte == $past(statusQ))
    else $error("status not prepended");
  chk_route_copy: assert property (
    @(posedge clk) disable iff (reset)
    clkEn |=> analogCtl.exciteRouteB == $past(exRouteQ[7:4]))
    else $error("route b not applied");

endmodule

`default_nettype wire

/* File: fmsc_pkg.sv */
// Package for the front-end monitor and status register bank
package fmsc_pkg;

  // Register word offsets (byte address = index * 4)
  localparam logic [7:0] IDX_STATUS  = 8'h01;
  localparam logic [7:0] IDX_GAIN    = 8'h03;
  localparam logic [7:0] IDX_EXMAG   = 8'h06;
  localparam logic [7:0] IDX_EXROUTE = 8'h07;
  localparam logic [7:0] IDX_BIAS    = 8'h08;
  localparam logic [7:0] IDX_SYSCTL  = 8'h09;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h80;
  localparam logic [7:0] RST_CFG    = 8'h00;

  // Field positions
  localparam int STAT_POR_BIT   = 7;
  localparam int STAT_RDYN_BIT  = 6;
  localparam int BIAS_LEVEL_BIT = 6;
  localparam int SYS_APPEND_BIT = 0;
  localparam int SYS_MON_LSB    = 5;
  localparam int GAIN_LSB       = 0;
  localparam int AMPEN_LSB      = 3;

  // Monitor selector codes and the unity gain code
  localparam logic [2:0] MON_TEMP  = 3'h2;
  localparam logic [2:0] MON_AVDD  = 3'h3;
  localparam logic [2:0] MON_DVDD  = 3'h4;
  localparam logic [2:0] MON_BO_02 = 3'h5;
  localparam logic [2:0] MON_BO_1  = 3'h6;
  localparam logic [2:0] MON_BO_10 = 3'h7;
  localparam logic [2:0] GAIN_ONE  = 3'h0;

  // Start-up hold-off before ready, in cycles
  localparam int STARTUP_CYCLES = 16;

  // Analog path controls leaving the block
  typedef struct packed {
    logic [3:0] exciteMagnitude;
    logic [3:0] exciteRouteA;
    logic [3:0] exciteRouteB;
    logic       biasLevelSel;
    logic [6:0] biasPinConnect;
    logic       tempSensorSel;
    logic       analogMonSel;
    logic       digitalMonSel;
    logic       inputsDisconnect;
    logic [2:0] ampGainEff;
    logic [1:0] ampEnableField;
    logic [1:0] burnoutLevel;
    logic       burnoutEnable;
    logic       statusAppend;
  } fmsc_analog_s;

  // Fault flags presented at the end of a conversion
  typedef struct packed {
    logic posOutHigh;
    logic posOutLow;
    logic negOutHigh;
    logic negOutLow;
    logic refThird;
    logic refLow;
  } fmsc_faults_s;

endpackage

/* File: fmsc_host_model.sv */
// Wishbone classic host model: one two-cycle access per go pulse, held until ack
`timescale 1ns/1ns
`default_nettype none
module fmsc_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command side
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [9:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic             done,
  output logic      [7:0]  rdata,
  // Bus side
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [9:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat,
  input  wire logic [31:0] datIn,
  input  wire logic        ack
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {cyc, stb, we, done, adr, sel, dat, rdata} <= '0;
    end else if (cyc && ack) begin
      // Released address and data lines are scrambled so the slave cannot lean on stale values
      {cyc, stb, done} <= 3'b001;
      dat <= ~dat;
      adr <= ~adr;
      rdata <= datIn[7:0];
    end else if (go && !cyc) begin
      {cyc, stb, we, done} <= {2'b11, wr, 1'b0};
      adr <= addr;
      sel <= 4'h1;
      dat <= {24'h0, wdata};
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test_frontend_monitor_status_ctrl.sv */
// Self-checking bench for the front-end register bank
`timescale 1ns/1ns
`default_nettype none
module test_frontend_monitor_status_ctrl import fmsc_pkg::*;;
  typedef struct packed {logic [7:0] idx, wd, rd;} fmsc_row_s;
  localparam fmsc_row_s ROWS [7] = '{'{IDX_EXMAG, 8'h0f, 8'h0f}, '{IDX_EXROUTE, 8'h99, 8'h99},
    '{IDX_BIAS, 8'hff, 8'hff}, '{IDX_GAIN, 8'h0a, 8'h0a}, '{8'h0f, 8'h5a, 8'h00},
    '{IDX_STATUS, 8'hff, 8'h80}, '{IDX_STATUS, 8'h7f, 8'h00}};
  logic         clk, reset, clkEn, go, wr, done, cyc, stb, we, ack;
  logic         convDone, dataByteReq, firstIsStatus;
  logic [9:0]   addr, adr;
  logic [7:0]   wdata, rdata, firstByte;
  logic [3:0]   sel;
  logic [31:0]  datW, datR;
  logic [2:0]   m;
  fmsc_faults_s faultsLive;
  fmsc_analog_s analogCtl;
  int           n_mismatch, num_checks, cycles;
  fmsc_frontend_regs #(.STARTUP(12)) DUT (.clk(clk), .reset(reset), .clkEn(clkEn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .convDone(convDone), .faultsLive(faultsLive), .dataByteReq(dataByteReq),
    .firstByte(firstByte), .firstIsStatus(firstIsStatus), .analogCtl(analogCtl));
  fmsc_host_model host (.clk(clk), .reset(reset), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(datW), .datIn(datR), .ack(ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    go <= 1'b1;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 50 && done !== 1'b1; k++) begin
      @(posedge clk);
    end
    if (k == 50) n_mismatch++;
    @(posedge clk);
  endtask
  // Reset pulse, then excitation magnitude register back to zero and power-on flag set with the active-low ready bit still high (not ready)
  task automatic rst_chk();
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    acc(1'b0, IDX_EXMAG, 8'h00);
    check(rdata, RST_CFG);
    acc(1'b0, IDX_STATUS, 8'h00);
    check(rdata, 8'hc0);
  endtask
  task automatic conv(input logic [5:0] f, input logic [7:0] prev, input logic [7:0] exp);
    faultsLive <= f;
    @(posedge clk);
    faultsLive <= '0;
    acc(1'b0, IDX_STATUS, 8'h00);
    check(rdata, prev);
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    acc(1'b0, IDX_STATUS, 8'h00);
    check(rdata, exp);
  endtask
  initial begin
    {reset, clkEn, go, wr, convDone, dataByteReq} = 6'h30;
    {addr, wdata, faultsLive} = '0;
    @(posedge clk);
    rst_chk();
    foreach (ROWS[i]) begin
      acc(1'b1, ROWS[i].idx, ROWS[i].wd);
      acc(1'b0, ROWS[i].idx, 8'h00);
      check(rdata, ROWS[i].rd);
    end
    check({analogCtl.exciteMagnitude, analogCtl.exciteRouteA, analogCtl.exciteRouteB},
      12'hf99);
    check({analogCtl.biasLevelSel, analogCtl.biasPinConnect}, 8'hff);
    // Gain code 2 keeps the temperature reading in range
    for (int c = 0; c < 8; c++) begin
      m = c[2:0];
      acc(1'b1, IDX_SYSCTL, {m, 5'h00});
      check({analogCtl.tempSensorSel, analogCtl.analogMonSel, analogCtl.digitalMonSel},
        {m == MON_TEMP, m == MON_AVDD, m == MON_DVDD});
      check({analogCtl.inputsDisconnect, analogCtl.ampGainEff}, (m == MON_AVDD ||
        m == MON_DVDD) ? 4'h8 : {m == MON_TEMP, 3'h2});
      check(analogCtl.ampEnableField, 2'h1);
      check({analogCtl.burnoutEnable, analogCtl.burnoutLevel},
        m >= MON_BO_02 ? {1'b1, m[1:0]} : 3'h0);
    end
    acc(1'b1, IDX_SYSCTL, 8'h00);
    conv(6'h01, 8'h00, 8'h01);
    conv(6'h3e, 8'h01, 8'h3e);
    for (int a = 1; a >= 0; a--) begin
      acc(1'b1, IDX_SYSCTL, {7'h00, a[0]});
      dataByteReq <= 1'b1;
      @(posedge clk);
      dataByteReq <= 1'b0;
      @(posedge clk);
      check({firstIsStatus, firstByte}, a ? 9'h13e : 9'h000);
    end
    conv(6'h00, 8'h3e, 8'h00);
    rst_chk();
    conclude();
  end
endmodule
`default_nettype wire
